// ### hdl/tccp_counter.sv
// prescaler and free-running modulo up-counter
`timescale 1ns/1ps
`include "tccp_regs.svh"
module tccp_counter (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic [2:0] ps_sel,
    input wire logic stop,
    input wire logic cnt_rst,
    input wire logic ext_clk_sync,
    input wire logic [15:0] modulo,
    // tick outputs
    tccp_tick_if.src tk
);
    import tccp_pkg::*;
    logic [6:0] div_ff;
    logic ext_d_ff;
    logic [15:0] cnt_ff;
    logic tick_c;
    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    // divider free-runs; a tick is its selected bit's all-ones point
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff <= 7'h00;
        end else if (cnt_rst) begin
            div_ff <= 7'h00;
        end else if (!stop) begin
            div_ff <= div_ff + 7'h01;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_d_ff <= 1'b0;
        end else begin
            ext_d_ff <= ext_clk_sync;
        end
    end
    // seven bus-clock divisions or the synchronised external clock rising edge
    always_comb begin
        case (ps_sel)
            3'h0: tick_c = 1'b1;
            3'h1: tick_c = div_ff[0];
            3'h2: tick_c = &div_ff[1:0];
            3'h3: tick_c = &div_ff[2:0];
            3'h4: tick_c = &div_ff[3:0];
            3'h5: tick_c = &div_ff[4:0];
            3'h6: tick_c = &div_ff[5:0];
            default: tick_c = ext_clk_sync & ~ext_d_ff;
        endcase
    end
    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 16'h0000;
        end else if (cnt_rst) begin
            cnt_ff <= 16'h0000;
        end else if (tick_c && !stop) begin
            cnt_ff <= (cnt_ff == modulo) ? 16'h0000 : cnt_ff + 16'h0001;
        end
    end
    assign tk.tick = tick_c & ~stop;
    assign tk.ovf = tick_c & ~stop & (cnt_ff == modulo);
    assign tk.count = cnt_ff;
endmodule : tccp_counter

// ### hdl/tccp_pkg.sv
// types shared by the capture/compare timer files
package tccp_pkg;
    typedef enum logic [1:0] {TCCP_ACT_NONE, TCCP_ACT_TOGGLE, TCCP_ACT_CLEAR, TCCP_ACT_SET} tccp_act_t;
    typedef logic [15:0] tccp_word_t;
endpackage : tccp_pkg

// ### hdl/tccp_regs.svh
// register offsets, field positions, reset values and timing counts of the capture/compare timer
`ifndef TCCP_REGS_SVH
`define TCCP_REGS_SVH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define TCCP_OFF_CTRL 12'h000
`define TCCP_OFF_COUNT 12'h004
`define TCCP_OFF_MODULO 12'h008
`define TCCP_OFF_CH0_CS 12'h00C
`define TCCP_OFF_CH0_VAL 12'h010
`define TCCP_OFF_CH1_CS 12'h014
`define TCCP_OFF_CH1_VAL 12'h018
// ----------------------------------------------------------------------
// timer control fields
// ----------------------------------------------------------------------
`define TCCP_CTRL_PS_LSB 0
`define TCCP_CTRL_STOP_BIT 4
`define TCCP_CTRL_RST_BIT 5
`define TCCP_CTRL_OVF_BIT 7
// ----------------------------------------------------------------------
// channel control/status fields
// ----------------------------------------------------------------------
`define TCCP_CS_MAX_BIT 0
`define TCCP_CS_TOV_BIT 1
`define TCCP_CS_ELSA_BIT 2
`define TCCP_CS_ELSB_BIT 3
`define TCCP_CS_MSA_BIT 4
`define TCCP_CS_MSB_BIT 5
`define TCCP_CS_FLAG_BIT 7
// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define TCCP_MODULO_RST 16'hFFFF
`define TCCP_CTRL_RST 8'h10
`define TCCP_PS_EXT 3'h7
`endif

// ### hdl/tccp_tick_if.sv
// counter tick and overflow signals passed from the prescaler/counter to the channels
`timescale 1ns/1ps
interface tccp_tick_if;
    logic tick;
    logic ovf;
    logic [15:0] count;
    modport src (output tick, output ovf, output count);
    modport dst (input tick, input ovf, input count);
endinterface : tccp_tick_if

// ### hdl/tccp_top.sv
// two-channel capture/compare/PWM timer with APB register access
//
// Notes on behaviour
// - an active capture edge copies the counter into the channel value
// - edge-select bits choose rising, falling or both edges
// - capture sets the channel flag, a request when its enable is set
// - compare match sets, clears or toggles the channel 0 pin
// - compare on either channel sets its flag (channel 0's flag when linked) and may request
// - channel 1 drives no pin; unlinked, its matches only set its flag
// - a new unbuffered value acts at once; a passed value misses
// - buffered select on channel 0 links both channels onto pin 0
// - linked: channel 0 first, then last-written channel at each overflow
// - linked: channel 0 control governs; channel 1 control is ignored
// - linked: writing the active channel acts immediately
// - toggle-on-overflow inverts the pin at each counter overflow; with the max bit set it sets the pin instead
// - modulo 255 undivided gives a 256-clock period
// - value 128 of 256 steps gives 50 percent duty
// - unsynchronised width writes may misbehave for two periods
// - seven bus divisions or external clock chosen by three bits
// - without toggle-on-overflow the pin moves only on compare actions
// - overflow flag sets when the counter wraps from modulo to zero
`timescale 1ns/1ps
`include "tccp_regs.svh"
module tccp_top (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // pins
    input wire logic EXTERNAL_TIMER_CLOCK,
    input wire logic CHANNEL0_PIN_IN,
    output logic CHANNEL0_PIN_OUT,
    output logic CHANNEL0_PIN_OE_N,
    // interrupt requests
    output logic OVF_IRQ,
    output logic CH0_IRQ,
    output logic CH1_IRQ
);
    import tccp_pkg::*;
    tccp_tick_if tk();
    logic [1:0] ext_sync_ff;
    logic [1:0] pin_sync_ff;
    logic pin_d_ff;
    logic [7:0] ctrl_ff;
    tccp_word_t modulo_ff;
    logic [7:0] cs_ff [2];
    tccp_word_t val_ff [2];
    logic active_ff;
    logic last_wr_ff;
    logic pin_ff;
    logic oe_n_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic ovf_irq_ff;
    logic ch_irq_ff [2];
    logic wr_acc, rd_acc, linked, cap_edge, cap0, buf_sel_c;
    logic [1:0] match_c;
    tccp_word_t nxt_count;
    logic ovf_clr, mapped_c;
    logic [1:0] flag_clr;
    logic [31:0] rd_c;
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ext_sync_ff <= 2'b00;
            pin_sync_ff <= 2'b00;
            pin_d_ff <= 1'b0;
        end else begin
            ext_sync_ff <= {ext_sync_ff[0], EXTERNAL_TIMER_CLOCK};
            pin_sync_ff <= {pin_sync_ff[0], CHANNEL0_PIN_IN};
            pin_d_ff <= pin_sync_ff[1];
        end
    end
    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    tccp_counter u_cnt (
        .clk(CLOCK),
        .rst(RST),
        .ps_sel(ctrl_ff[`TCCP_CTRL_PS_LSB +: 3]),
        .stop(ctrl_ff[`TCCP_CTRL_STOP_BIT]),
        .cnt_rst(ctrl_ff[`TCCP_CTRL_RST_BIT]),
        .ext_clk_sync(ext_sync_ff[1]),
        .modulo(modulo_ff),
        .tk(tk.src)
    );
    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // one wait state: answer lands in the cycle after the access phase starts
    assign wr_acc = PSEL & PENABLE & PWRITE & pready_ff;
    assign rd_acc = PSEL & PENABLE & ~PWRITE & ~pready_ff;
    assign linked = cs_ff[0][`TCCP_CS_MSB_BIT];
    // capture on channel 0 only when it is in input capture mode
    assign cap0 = ~cs_ff[0][`TCCP_CS_MSA_BIT] & ~linked;
    always_comb begin
        case ({cs_ff[0][`TCCP_CS_ELSB_BIT], cs_ff[0][`TCCP_CS_ELSA_BIT]})
            2'b01: cap_edge = pin_sync_ff[1] & ~pin_d_ff;
            2'b10: cap_edge = ~pin_sync_ff[1] & pin_d_ff;
            2'b11: cap_edge = pin_sync_ff[1] ^ pin_d_ff;
            default: cap_edge = 1'b0;
        endcase
    end
    // compares act on the tick that brings the counter to the value, as overflow acts on wrap,
    // so a value of half the period gives exactly half the period high
    assign nxt_count = (tk.count == modulo_ff) ? 16'h0000 : tk.count + 16'h0001;
    // in linked mode only the active channel compares; channel 1 is otherwise standalone
    assign match_c[0] = tk.tick & cs_ff[0][`TCCP_CS_MSA_BIT] & ~linked
        & (nxt_count == val_ff[0]);
    assign match_c[1] = tk.tick & (linked ? (nxt_count == val_ff[active_ff])
        : (cs_ff[1][`TCCP_CS_MSA_BIT] & (nxt_count == val_ff[1])));
    assign ovf_clr = wr_acc & (PADDR == `TCCP_OFF_CTRL) & ~PWDATA[`TCCP_CTRL_OVF_BIT];
    assign flag_clr[0] = wr_acc & (PADDR == `TCCP_OFF_CH0_CS) & ~PWDATA[`TCCP_CS_FLAG_BIT];
    assign flag_clr[1] = wr_acc & (PADDR == `TCCP_OFF_CH1_CS) & ~PWDATA[`TCCP_CS_FLAG_BIT];
    assign buf_sel_c = wr_acc & (PADDR == `TCCP_OFF_CH1_VAL);
    // ------------------------------------------------------------------
    // timer control and modulo
    // ------------------------------------------------------------------
    // overflow flag: set wins over a software clear in the same cycle
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ctrl_ff <= `TCCP_CTRL_RST;
        end else begin
            if (wr_acc && PADDR == `TCCP_OFF_CTRL) begin
                ctrl_ff[6:0] <= PWDATA[6:0];
            end else begin
                ctrl_ff[`TCCP_CTRL_RST_BIT] <= 1'b0; // counter reset is self-clearing
            end
            if (tk.ovf) begin
                ctrl_ff[`TCCP_CTRL_OVF_BIT] <= 1'b1;
            end else if (ovf_clr) begin
                ctrl_ff[`TCCP_CTRL_OVF_BIT] <= 1'b0;
            end
        end
    end
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            modulo_ff <= `TCCP_MODULO_RST;
        end else if (wr_acc && PADDR == `TCCP_OFF_MODULO) begin
            modulo_ff <= PWDATA[15:0];
        end
    end
    // ------------------------------------------------------------------
    // channel control, values and flags, one per channel
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam logic [11:0] CS_OFF = i ? `TCCP_OFF_CH1_CS : `TCCP_OFF_CH0_CS;
        localparam logic [11:0] VAL_OFF = i ? `TCCP_OFF_CH1_VAL : `TCCP_OFF_CH0_VAL;
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                cs_ff[i] <= 8'h00;
            end else begin
                if (wr_acc && PADDR == CS_OFF) begin
                    cs_ff[i][5:0] <= (i == 1) ? {1'b0, PWDATA[4:0]} : PWDATA[5:0];
                    cs_ff[i][6] <= PWDATA[6];
                end
                // linked compares report through channel 0's flag
                if ((i == 0 && ((cap0 && cap_edge) || match_c[0] || (linked && match_c[1])))
                    || (i == 1 && !linked && match_c[1])) begin
                    cs_ff[i][`TCCP_CS_FLAG_BIT] <= 1'b1;
                end else if (flag_clr[i]) begin
                    cs_ff[i][`TCCP_CS_FLAG_BIT] <= 1'b0;
                end
            end
        end
        // value register: software write, or a capture on channel 0
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                val_ff[i] <= 16'h0000;
            end else if (i == 0 && cap0 && cap_edge) begin
                val_ff[i] <= tk.count;
            end else if (wr_acc && PADDR == VAL_OFF) begin
                val_ff[i] <= PWDATA[15:0];
            end
        end
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                ch_irq_ff[i] <= 1'b0;
            end else begin
                ch_irq_ff[i] <= cs_ff[i][`TCCP_CS_FLAG_BIT] & cs_ff[i][6];
            end
        end
    end
    // ------------------------------------------------------------------
    // buffered channel selection
    // ------------------------------------------------------------------
    // the last-written channel takes over at the next overflow
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            active_ff <= 1'b0;
            last_wr_ff <= 1'b0;
        end else if (!linked) begin
            active_ff <= 1'b0;
            last_wr_ff <= 1'b0;
        end else begin
            if (buf_sel_c) begin
                last_wr_ff <= 1'b1;
            end else if (wr_acc && PADDR == `TCCP_OFF_CH0_VAL) begin
                last_wr_ff <= 1'b0;
            end
            if (tk.ovf) begin
                active_ff <= last_wr_ff;
            end
        end
    end
    // ------------------------------------------------------------------
    // channel 0 pin
    // ------------------------------------------------------------------
    // overflow toggle wins over a compare action in the same cycle; channel 1 has no pin
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pin_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end else begin
            oe_n_ff <= cap0;
            if (tk.ovf && cs_ff[0][`TCCP_CS_TOV_BIT] && !cap0) begin
                pin_ff <= cs_ff[0][`TCCP_CS_MAX_BIT] ? 1'b1 : ~pin_ff;
            end else if ((match_c[0] || (linked && match_c[1]))
                && !cs_ff[0][`TCCP_CS_MAX_BIT]) begin
                case ({cs_ff[0][`TCCP_CS_ELSB_BIT], cs_ff[0][`TCCP_CS_ELSA_BIT]})
                    2'b01: pin_ff <= ~pin_ff;
                    2'b10: pin_ff <= 1'b0;
                    2'b11: pin_ff <= 1'b1;
                    default: pin_ff <= pin_ff;
                endcase
            end
        end
    end
    // ------------------------------------------------------------------
    // apb read path and interrupt outputs
    // ------------------------------------------------------------------
    always_comb begin
        rd_c = 32'h0000_0000;
        mapped_c = 1'b1;
        case (PADDR)
            `TCCP_OFF_CTRL: rd_c = {24'h000000, ctrl_ff};
            `TCCP_OFF_COUNT: rd_c = {16'h0000, tk.count};
            `TCCP_OFF_MODULO: rd_c = {16'h0000, modulo_ff};
            `TCCP_OFF_CH0_CS: rd_c = {24'h000000, cs_ff[0]};
            `TCCP_OFF_CH0_VAL: rd_c = {16'h0000, val_ff[0]};
            `TCCP_OFF_CH1_CS: rd_c = {24'h000000, cs_ff[1]};
            `TCCP_OFF_CH1_VAL: rd_c = {16'h0000, val_ff[1]};
            default: mapped_c = 1'b0;
        endcase
    end
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            ovf_irq_ff <= 1'b0;
        end else begin
            pready_ff <= PSEL & PENABLE & ~pready_ff;
            pslverr_ff <= PSEL & PENABLE & ~pready_ff & ~mapped_c;
            if (rd_acc) begin
                prdata_ff <= rd_c;
            end
            ovf_irq_ff <= ctrl_ff[`TCCP_CTRL_OVF_BIT] & ctrl_ff[6];
        end
    end
    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign CHANNEL0_PIN_OUT = pin_ff;
    assign CHANNEL0_PIN_OE_N = oe_n_ff;
    assign OVF_IRQ = ovf_irq_ff;
    assign CH0_IRQ = ch_irq_ff[0];
    assign CH1_IRQ = ch_irq_ff[1];
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_CAPTURE: assert property (@(posedge CLOCK) disable iff (RST)
        (cap0 && cap_edge) |=> val_ff[0] == $past(tk.count)) else $error("capture value wrong");
    AST_OVF_FLAG: assert property (@(posedge CLOCK) disable iff (RST)
        tk.ovf |=> ctrl_ff[`TCCP_CTRL_OVF_BIT]) else $error("overflow flag not set");
    AST_WRAP: assert property (@(posedge CLOCK) disable iff (RST)
        tk.ovf && !ctrl_ff[`TCCP_CTRL_RST_BIT] |=> tk.count == 16'h0000) else $error("no wrap");
    AST_TOGGLE: assert property (@(posedge CLOCK) disable iff (RST)
        (tk.ovf && cs_ff[0][1] && !cap0 && !cs_ff[0][0]) |=> pin_ff != $past(pin_ff))
        else $error("no toggle at overflow");
    AST_CLEAR: assert property (@(posedge CLOCK) disable iff (RST)
        (match_c[0] && !tk.ovf && cs_ff[0][3:2] == 2'b10 && !cs_ff[0][0]) |=> !pin_ff)
        else $error("compare clear failed");
    AST_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
        (!cs_ff[0][1] && !match_c[0] && !match_c[1]) |=> $stable(pin_ff))
        else $error("pin moved without cause");
    AST_SWAP: assert property (@(posedge CLOCK) disable iff (RST)
        (linked && tk.ovf) |=> active_ff == $past(last_wr_ff)) else $error("buffer swap wrong");
    AST_CH1_FLAG: assert property (@(posedge CLOCK) disable iff (RST)
        (match_c[1] && !linked) |=> cs_ff[1][7]) else $error("channel 1 flag missing");
    AST_READY: assert property (@(posedge CLOCK) disable iff (RST)
        (PSEL && PENABLE && !PREADY) |=> PREADY) else $error("apb answer late");
    COV_CAPTURE: cover property (@(posedge CLOCK) disable iff (RST) cap0 && cap_edge);
    COV_LINK_SWAP: cover property (@(posedge CLOCK) disable iff (RST) linked && tk.ovf && last_wr_ff);
    COV_PWM: cover property (@(posedge CLOCK) disable iff (RST) tk.ovf && cs_ff[0][1]);
endmodule : tccp_top

// ### verification/tccp_pin_partner.sv
// pin-side partner of the timer: capture event source and pwm load monitor
`timescale 1ns/1ps
module tccp_pin_partner (
    // clock
    input wire logic clk,
    // pin level as seen on the wire
    input wire logic pin_wire,
    // event source drive, used while the timer does not drive the pin
    output logic src_level
);
    // ----------------------------------------------------------------------
    // event source and load
    // ----------------------------------------------------------------------
    // source idles low so the first requested rise is a real edge
    initial src_level = 1'b0;

    // one edge, then held past the timer's two-flop synchroniser
    task automatic drive_edge(input logic level);
        @(posedge clk);
        src_level <= level;
        repeat (6) @(posedge clk);
    endtask : drive_edge

    // high time and period from one rising edge to the next; waits are bounded
    task automatic measure(output logic [15:0] high_cyc, output logic [15:0] per_cyc);
        int n;
        n = 0;
        high_cyc = 16'h0000;
        per_cyc = 16'h0000;
        while (pin_wire === 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        while (pin_wire !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        while (pin_wire === 1'b1 && n < 3000) begin
            @(posedge clk);
            high_cyc++;
            n++;
        end
        per_cyc = high_cyc;
        while (pin_wire !== 1'b1 && n < 4000) begin
            @(posedge clk);
            per_cyc++;
            n++;
        end
    endtask : measure
endmodule : tccp_pin_partner

// ### verification/timer_capture_compare_pwm_test.sv
// self-checking testbench of the capture/compare/pwm timer
`timescale 1ns/1ps
`include "tccp_regs.svh"
module timer_capture_compare_pwm_test;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cnt;
    logic ext_clk, pin_out, pin_oe_n, src_level, pin_wire, ovf_irq, ch0_irq, ch1_irq;
    logic [15:0] h_half, h_a, h_b, per, v, n_high;
    int num_errors = 0;
    int compares = 0;

    // wire level: the timer's driver wins whenever it is enabled
    assign pin_wire = (pin_oe_n === 1'b0) ? pin_out : src_level;

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // external timer clock runs free, rising every eight bus cycles
    initial begin
        ext_clk = 1'b0;
        forever begin
            repeat (4) @(posedge clock);
            ext_clk <= ~ext_clk;
        end
    end

    tccp_top DUT (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXTERNAL_TIMER_CLOCK(ext_clk),
        .CHANNEL0_PIN_IN(pin_wire), .CHANNEL0_PIN_OUT(pin_out),
        .CHANNEL0_PIN_OE_N(pin_oe_n), .OVF_IRQ(ovf_irq), .CH0_IRQ(ch0_irq),
        .CH1_IRQ(ch1_irq));

    tccp_pin_partner partner (.clk(clock), .pin_wire(pin_wire), .src_level(src_level));

    // ----------------------------------------------------------------------
    // bus, compare and verdict tasks
    // ----------------------------------------------------------------------
    task automatic final_report;
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) chk("pready", 32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // capture edge table: bit 0 of the mode takes rises, bit 1 falls
    function automatic logic edge_hits(input logic [1:0] mode, input logic level);
        return level ? mode[0] : mode[1];
    endfunction : edge_hits

    // ----------------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clock);
        num_errors++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(86214));
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, `TCCP_OFF_CTRL, 32'h0);
        chk("ctrl_reset", 32'h00000010, rd);
        apb(1'b0, `TCCP_OFF_MODULO, 32'h0);
        chk("modulo_reset", 32'h0000FFFF, rd);
        apb(1'b1, 12'h01C, 32'h000000FF);
        chk("unmapped_err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped_rd", 32'h0, rd);
        // capture: every edge mode against a rise then a fall, counter frozen
        for (int m = 1; m < 4; m++) begin
            for (int lv = 1; lv >= 0; lv--) begin
                wr(`TCCP_OFF_CTRL, 32'h00000000);
                repeat ($urandom_range(20, 200)) @(posedge clock);
                wr(`TCCP_OFF_CTRL, 32'h00000010);
                apb(1'b0, `TCCP_OFF_COUNT, 32'h0);
                cnt = rd;
                wr(`TCCP_OFF_CH0_CS, 32'h40 | (m << 2));
                partner.drive_edge(lv[0]);
                apb(1'b0, `TCCP_OFF_CH0_CS, 32'h0);
                chk("cap_flag", {31'h0, edge_hits(m[1:0], lv[0])}, {31'h0, rd[7]});
                chk("cap_irq", {31'h0, edge_hits(m[1:0], lv[0])}, {31'h0, ch0_irq});
                apb(1'b0, `TCCP_OFF_CH0_VAL, 32'h0);
                if (edge_hits(m[1:0], lv[0])) chk("cap_val", cnt & 32'hFFFF, rd & 32'hFFFF);
            end
        end
        // unbuffered pwm, clear on compare; channel 1 sets on compare
        wr(`TCCP_OFF_CTRL, 32'h00000030);
        wr(`TCCP_OFF_MODULO, 32'h000000FF);
        wr(`TCCP_OFF_CH0_VAL, 32'h00000080);
        wr(`TCCP_OFF_CH1_CS, 32'h0000005C);
        wr(`TCCP_OFF_CH1_VAL, 32'h000000C8);
        wr(`TCCP_OFF_CH0_CS, 32'h0000001A);
        wr(`TCCP_OFF_CTRL, 32'h00000040);
        repeat (2) partner.measure(h_half, per);
        chk("pwm_period", 32'h100, {16'h0, per});
        chk("pwm_half", 32'h80, {16'h0, h_half});
        v = 16'($urandom_range(16, 240));
        wr(`TCCP_OFF_CH0_VAL, {16'h0, v});
        repeat (3) partner.measure(h_a, per);
        chk("pwm_step", {16'h0, v - 16'd128}, {16'h0, h_a - h_half});
        // smaller width written just after the compare, so the running period is left alone
        while (pin_wire === 1'b1) @(posedge clock);
        wr(`TCCP_OFF_CH0_VAL, {16'h0, v >> 1});
        partner.measure(h_b, per);
        chk("pwm_small", {16'h0, v >> 1}, {16'h0, h_b});
        apb(1'b0, `TCCP_OFF_CTRL, 32'h0);
        chk("ovf_flag", 32'h1, {31'h0, rd[7]});
        chk("ovf_irq", 32'h1, {31'h0, ovf_irq});
        chk("ch1_irq", 32'h1, {31'h0, ch1_irq});
        // linked pair: channel 0 first, channel 1 after its write and an overflow
        wr(`TCCP_OFF_CH0_VAL, 32'h00000040);
        wr(`TCCP_OFF_CH0_CS, 32'h0000002A);
        repeat (3) partner.measure(h_a, per);
        chk("linked_first", {16'h0, h_half - 16'd64}, {16'h0, h_a});
        wr(`TCCP_OFF_CH1_VAL, 32'h000000C0);
        repeat (2) partner.measure(h_b, per);
        chk("linked_second", 32'h80, {16'h0, h_b - h_a});
        // no toggle on overflow: the pin is cleared and stays low
        wr(`TCCP_OFF_CH0_CS, 32'h00000018);
        repeat (300) @(posedge clock);
        n_high = 16'h0000;
        repeat (600) begin
            @(posedge clock);
            if (pin_wire !== 1'b0) n_high++;
        end
        chk("no_toggle", 32'h0, {16'h0, n_high});
        // prescaler: bus clock halved, then the external clock rising every eight cycles
        wr(`TCCP_OFF_CTRL, 32'h00000030);
        wr(`TCCP_OFF_MODULO, 32'h0000001F);
        wr(`TCCP_OFF_CH0_VAL, 32'h00000010);
        wr(`TCCP_OFF_CH0_CS, 32'h0000001A);
        wr(`TCCP_OFF_CTRL, 32'h00000001);
        repeat (2) partner.measure(h_a, per);
        chk("div2_period", 32'h40, {16'h0, per});
        chk("div2_high", 32'h20, {16'h0, h_a});
        wr(`TCCP_OFF_CTRL, 32'h00000007);
        repeat (2) partner.measure(h_a, per);
        chk("ext_period", 32'h100, {16'h0, per});
        chk("ext_high", 32'h80, {16'h0, h_a});
        final_report();
    end
endmodule : timer_capture_compare_pwm_test
